// ---- dsk_defs.vh ----
// Purpose: shared constants of the diskette sector error control block
// Assumes: 100 MHz core clock, word addressed register bus
// Notes: definitions only
`ifndef DSK_DEFS_VH
`define DSK_DEFS_VH

// register word indices on the bus
`define DSK_REG_CMD 3'h0
`define DSK_REG_STATUS 3'h1
`define DSK_REG_CUR_ADDR 3'h2
`define DSK_REG_IRQ_STAT 3'h3
`define DSK_REG_IRQ_MASK 3'h4
`define DSK_REG_DEV_CODE 3'h5

// command register fields
`define DSK_CMD_OP_MSB 2
`define DSK_CMD_OP_LSB 0
`define DSK_CMD_SEC_MSB 6
`define DSK_CMD_SEC_LSB 4
`define DSK_CMD_TRK_MSB 14
`define DSK_CMD_TRK_LSB 8
`define DSK_CMD_RESET 16'h0000

// command codes
`define DSK_OP_RD_PRE 3'h0
`define DSK_OP_RD_DATA 3'h1
`define DSK_OP_WR_DATA 3'h2
`define DSK_OP_FMT_FIRST 3'h3
`define DSK_OP_FMT_NEXT 3'h4

// status register bit positions
`define DSK_ST_BUSY 0
`define DSK_ST_DONE 1
`define DSK_ST_ERR 2
`define DSK_ST_ADDR_ERR 3
`define DSK_ST_CK_ERR 4
`define DSK_ST_LATE 5
`define DSK_ST_ILLEGAL 6
`define DSK_ST_NR_LATCH 7
`define DSK_ST_NR 8
`define DSK_ST_WP 9

// interrupt status bits
`define DSK_IRQ_DONE 0
`define DSK_IRQ_ERR 1

// sector preamble layout, in words
`define DSK_PRE_SYNC_A 9'd22
`define DSK_PRE_SYNC_WORD 16'h0001
`define DSK_PRE_SYNC_D 9'd12
`define DSK_PRE_IGNORE 9'd220
`define DSK_SECTOR_WORDS 9'd256

// current address word layout
`define DSK_ADDR_SEC_MSB 2
`define DSK_ADDR_TRK_MSB 14
`define DSK_ADDR_TRK_LSB 8
`define DSK_CK_SEED 16'hffff

// timing: data channel deadline and no-data timeout
`define DSK_CLK_MHZ 100
`define DSK_LATE_US 64
`define DSK_LATE_CYC (`DSK_LATE_US * `DSK_CLK_MHZ)
`define DSK_NODATA_US 170000
`define DSK_NODATA_CYC (`DSK_NODATA_US * `DSK_CLK_MHZ)

`endif

// ---- dsk_preamble.v ----
// Purpose: walks the preamble of one sector and extracts its address word
// Assumes: word_slot_i is a one-cycle pulse per word with rd_word_i stable
// Notes: preamble_bad_ff marks a sector whose sync fields do not match
`timescale 1ns/100ps
`include "dsk_defs.vh"

module dsk_preamble (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire start_i,
   input wire word_slot_i,
   input wire [15:0] rd_word_i,
   output reg [15:0] addr_ff,
   output reg addr_valid_ff,
   output reg preamble_done_ff,
   output reg preamble_bad_ff
);
   localparam P_IDLE = 3'd0;
   localparam P_SYNC_A = 3'd1;
   localparam P_SYNC_B = 3'd2;
   localparam P_ADDR = 3'd3;
   localparam P_SYNC_D = 3'd4;
   localparam P_SKIP = 3'd5;

   reg [2:0] state_ff;
   reg [8:0] cnt_ff;

   ////////////////////////////////////////////////////////////////////////
   // preamble walker, one step per word slot
   always @(posedge core_clk_i) begin
      addr_valid_ff <= 1'b0;
      preamble_done_ff <= 1'b0;
      preamble_bad_ff <= 1'b0;
      if (!reset_n_i) begin
         state_ff <= P_IDLE;
         cnt_ff <= 9'd0;
         addr_ff <= 16'h0000;
      end else if (start_i) begin
         state_ff <= P_SYNC_A;
         cnt_ff <= 9'd0;
      end else if (word_slot_i) begin
         case (state_ff)
            P_SYNC_A: begin
               if (rd_word_i != 16'h0000) begin
                  preamble_bad_ff <= 1'b1;
                  state_ff <= P_IDLE;
               end else if (cnt_ff == `DSK_PRE_SYNC_A - 9'd1) begin
                  state_ff <= P_SYNC_B;
               end else begin
                  cnt_ff <= cnt_ff + 9'd1;
               end
            end
            P_SYNC_B: begin
               if (rd_word_i == `DSK_PRE_SYNC_WORD) begin
                  state_ff <= P_ADDR;
               end else begin
                  preamble_bad_ff <= 1'b1;
                  state_ff <= P_IDLE;
               end
            end
            P_ADDR: begin
               addr_ff <= rd_word_i;
               addr_valid_ff <= 1'b1;
               cnt_ff <= 9'd0;
               state_ff <= P_SYNC_D;
            end
            P_SYNC_D: begin
               if (rd_word_i != 16'h0000) begin
                  preamble_bad_ff <= 1'b1;
                  state_ff <= P_IDLE;
               end else if (cnt_ff == `DSK_PRE_SYNC_D - 9'd1) begin
                  cnt_ff <= 9'd0;
                  state_ff <= P_SKIP;
               end else begin
                  cnt_ff <= cnt_ff + 9'd1;
               end
            end
            P_SKIP: begin
               // contents of this area are not looked at
               if (cnt_ff == `DSK_PRE_IGNORE - 9'd1) begin
                  preamble_done_ff <= 1'b1;
                  state_ff <= P_IDLE;
               end else begin
                  cnt_ff <= cnt_ff + 9'd1;
               end
            end
            default: begin
               state_ff <= P_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- dsk_ctrl.v ----
// Purpose: sector address check, checkword, data-late, protect and illegal handling
// Assumes: drive pins are asynchronous; data channel and bus share core_clk_i
// Notes: registers on Avalon-MM, one wait cycle per access
`timescale 1ns/100ps
`include "dsk_defs.vh"

module dsk_ctrl #(
   parameter LATE_CYCLES = `DSK_LATE_CYC,
   parameter NODATA_CYCLES = `DSK_NODATA_CYC
) (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire [2:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   output reg irq_o,
   output reg dch_req_o,
   output reg dch_to_mem_o,
   output reg [15:0] dch_wdata_o,
   input wire dch_ack_i,
   input wire [15:0] dch_rdata_i,
   input wire word_slot_i,
   input wire sector_mark_i,
   input wire index_mark_i,
   input wire [15:0] rd_word_i,
   input wire write_protect_i,
   input wire not_ready_i,
   input wire [5:0] code_jumper_i,
   output reg wr_gate_o,
   output reg wr_strobe_o,
   output reg [15:0] wr_word_o
);
   localparam S_IDLE = 3'd0;
   localparam S_MARK = 3'd1;
   localparam S_PRE = 3'd2;
   localparam S_DATA = 3'd3;
   localparam S_CHK = 3'd4;
   localparam S_TAIL = 3'd5;
   localparam S_END = 3'd6;
   localparam [24:0] LATE_CNT = LATE_CYCLES;
   localparam [24:0] NODATA_CNT = NODATA_CYCLES;

   reg [2:0] state_ff;
   reg [15:0] cmd_ff;
   reg [15:0] cur_addr_ff;
   reg [15:0] buf_ff;
   reg [15:0] ck_ff;
   reg [7:0] word_cnt_ff;
   reg [24:0] late_cnt_ff;
   reg [24:0] nodata_cnt_ff;
   reg busy_ff, done_ff, err_ff, addr_err_ff, ck_err_ff, late_ff, illegal_ff, nr_latch_ff;
   reg [1:0] irq_stat_ff;
   reg [1:0] irq_mask_ff;
   reg [28:0] sync1_ff;
   reg [28:0] sync2_ff;
   reg [2:0] edge_ff;
   reg pre_start_ff;
   reg end_evt_ff;
   wire [15:0] pre_addr;
   wire pre_addr_valid;
   wire pre_done;
   wire pre_bad;

   // synchronised pin views
   wire slot_s = sync2_ff[0];
   wire mark_s = sync2_ff[1];
   wire index_s = sync2_ff[2];
   wire wp_s = sync2_ff[3];
   wire nr_s = sync2_ff[4];
   wire [15:0] rd_word_s = sync2_ff[20:5];
   wire [5:0] code_s = sync2_ff[26:21];
   wire slot_p = slot_s & ~edge_ff[0];
   wire mark_p = mark_s & ~edge_ff[1];
   wire index_p = index_s & ~edge_ff[2];

   // decoded command
   wire [2:0] op = cmd_ff[`DSK_CMD_OP_MSB:`DSK_CMD_OP_LSB];
   wire is_read = (op == `DSK_OP_RD_DATA);
   wire is_fmt = (op == `DSK_OP_FMT_FIRST) || (op == `DSK_OP_FMT_NEXT);
   wire is_wr = (op == `DSK_OP_WR_DATA) || is_fmt;
   wire [2:0] want_sec = cmd_ff[`DSK_CMD_SEC_LSB + 2:`DSK_CMD_SEC_LSB];
   wire [6:0] want_trk = cmd_ff[`DSK_CMD_TRK_MSB:`DSK_CMD_TRK_LSB];

   // bus access handshake
   wire acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
   wire wr_acc = avs_write_i & ~avs_waitrequest_o;
   wire cmd_wr = wr_acc && (avs_address_i == `DSK_REG_CMD);
   wire [15:0] new_cmd = avs_writedata_i[15:0];
   wire [2:0] new_op = new_cmd[`DSK_CMD_OP_MSB:`DSK_CMD_OP_LSB];
   wire new_illegal = (new_op > `DSK_OP_FMT_NEXT);
   wire new_wr = (new_op == `DSK_OP_WR_DATA) || (new_op == `DSK_OP_FMT_FIRST) || (new_op == `DSK_OP_FMT_NEXT);

   wire [15:0] status_word = {6'h00, wp_s, nr_s, nr_latch_ff, illegal_ff, late_ff, ck_err_ff,
                              addr_err_ff, err_ff, done_ff, busy_ff};

   ////////////////////////////////////////////////////////////////////////////////////
   // preamble walker
   dsk_preamble u_pre (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .start_i(pre_start_ff),
      .word_slot_i(slot_p),
      .rd_word_i(rd_word_s),
      .addr_ff(pre_addr),
      .addr_valid_ff(pre_addr_valid),
      .preamble_done_ff(pre_done),
      .preamble_bad_ff(pre_bad)
   );

   ////////////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers on every drive pin and jumper, then edge history
   always @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         sync1_ff <= 29'h0;
         sync2_ff <= 29'h0;
         edge_ff <= 3'h0;
      end else begin
         sync1_ff <= {2'b00, code_jumper_i, rd_word_i, not_ready_i, write_protect_i,
                      index_mark_i, sector_mark_i, word_slot_i};
         sync2_ff <= sync1_ff;
         edge_ff <= sync2_ff[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // bus slave: waitrequest drops for one cycle, read data ready at that edge
   always @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
      end else begin
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
         if (avs_address_i == `DSK_REG_CMD) begin
            avs_readdata_o <= {16'h0000, cmd_ff};
         end else if (avs_address_i == `DSK_REG_STATUS) begin
            avs_readdata_o <= {16'h0000, status_word};
         end else if (avs_address_i == `DSK_REG_CUR_ADDR) begin
            avs_readdata_o <= {16'h0000, cur_addr_ff};
         end else if (avs_address_i == `DSK_REG_IRQ_STAT) begin
            avs_readdata_o <= {30'h0, irq_stat_ff};
         end else if (avs_address_i == `DSK_REG_IRQ_MASK) begin
            avs_readdata_o <= {30'h0, irq_mask_ff};
         end else if (avs_address_i == `DSK_REG_DEV_CODE) begin
            avs_readdata_o <= {26'h0, code_s};
         end else begin
            avs_readdata_o <= 32'h0; // unmapped reads as zero
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // interrupt status (write one to clear, set wins), mask and output
   always @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         irq_stat_ff <= 2'b00;
         irq_mask_ff <= 2'b00;
         irq_o <= 1'b0;
         nr_latch_ff <= 1'b0;
      end else begin
         if (wr_acc && avs_address_i == `DSK_REG_IRQ_MASK) begin
            irq_mask_ff <= avs_writedata_i[1:0];
         end
         if (wr_acc && avs_address_i == `DSK_REG_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~avs_writedata_i[1:0]) | {end_evt_ff & err_ff, end_evt_ff};
         end else begin
            irq_stat_ff <= irq_stat_ff | {end_evt_ff & err_ff, end_evt_ff};
         end
         irq_o <= |(irq_stat_ff & irq_mask_ff);
         // not-ready latch held for software, cleared by writing its status bit
         if (wr_acc && avs_address_i == `DSK_REG_STATUS && avs_writedata_i[`DSK_ST_NR_LATCH]) begin
            nr_latch_ff <= nr_s;
         end else begin
            nr_latch_ff <= nr_latch_ff | nr_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // operation sequencer
   always @(posedge core_clk_i) begin
      pre_start_ff <= 1'b0;
      end_evt_ff <= 1'b0;
      wr_strobe_o <= 1'b0;
      if (!reset_n_i) begin
         state_ff <= S_IDLE;
         cmd_ff <= `DSK_CMD_RESET;
         cur_addr_ff <= 16'h0000;
         buf_ff <= 16'h0000;
         ck_ff <= `DSK_CK_SEED;
         word_cnt_ff <= 8'h00;
         late_cnt_ff <= 25'h0;
         nodata_cnt_ff <= 25'h0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         addr_err_ff <= 1'b0;
         ck_err_ff <= 1'b0;
         late_ff <= 1'b0;
         illegal_ff <= 1'b0;
         dch_req_o <= 1'b0;
         dch_to_mem_o <= 1'b0;
         dch_wdata_o <= 16'h0000;
         wr_gate_o <= 1'b0;
         wr_word_o <= 16'h0000;
      end else begin
         // error summary follows every error flag until the next command
         err_ff <= err_ff | addr_err_ff | ck_err_ff | late_ff | illegal_ff;

         // data channel: answer takes or delivers the buffered word
         if (dch_ack_i && dch_req_o) begin
            dch_req_o <= 1'b0;
            if (!dch_to_mem_o) begin
               buf_ff <= dch_rdata_i;
            end
         end
         // deadline on a pending request
         if (dch_req_o && !(dch_ack_i)) begin
            if (late_cnt_ff == LATE_CNT - 25'd1) begin
               late_ff <= 1'b1;
               err_ff <= 1'b1;
            end
            if (late_cnt_ff != LATE_CNT) begin
               late_cnt_ff <= late_cnt_ff + 25'd1;
            end
         end else begin
            late_cnt_ff <= 25'h0;
         end

         case (state_ff)
            S_IDLE: begin
               if (cmd_wr) begin
                  cmd_ff <= new_cmd;
                  busy_ff <= 1'b1;
                  done_ff <= 1'b0;
                  err_ff <= 1'b0;
                  addr_err_ff <= 1'b0;
                  ck_err_ff <= 1'b0;
                  late_ff <= 1'b0;
                  illegal_ff <= 1'b0;
                  nodata_cnt_ff <= 25'h0;
                  word_cnt_ff <= 8'h00;
                  ck_ff <= `DSK_CK_SEED;
                  if (new_illegal) begin
                     illegal_ff <= 1'b1;
                     state_ff <= S_END;
                  end else if (new_wr && wp_s) begin
                     state_ff <= S_END;
                  end else begin
                     if (new_wr) begin
                        dch_to_mem_o <= 1'b0; // fetch first word ahead of the sector
                        dch_req_o <= 1'b1;
                     end
                     state_ff <= S_MARK;
                  end
               end
            end
            S_MARK: begin
               // format-first starts on the index, the rest on a sector mark
               if ((op == `DSK_OP_FMT_FIRST) ? index_p : mark_p) begin
                  if (is_fmt) begin
                     wr_gate_o <= 1'b1;
                     state_ff <= S_DATA;
                  end else begin
                     pre_start_ff <= 1'b1;
                     state_ff <= S_PRE;
                  end
               end
            end
            S_PRE: begin
               if (pre_addr_valid) begin
                  cur_addr_ff <= pre_addr;
                  nodata_cnt_ff <= 25'h0;
                  if (op == `DSK_OP_RD_PRE) begin
                     state_ff <= S_END;
                  end else if (pre_addr[`DSK_ADDR_SEC_MSB:0] != want_sec ||
                               pre_addr[`DSK_ADDR_TRK_MSB:`DSK_ADDR_TRK_LSB] != want_trk) begin
                     addr_err_ff <= 1'b1;
                     err_ff <= 1'b1;
                     state_ff <= S_END;
                  end
               end else if (pre_bad) begin
                  state_ff <= S_MARK; // not a sector start, wait for the next one
               end else if (pre_done) begin
                  wr_gate_o <= is_wr;
                  state_ff <= S_DATA;
               end
            end
            S_DATA: begin
               if (slot_p) begin
                  word_cnt_ff <= word_cnt_ff + 8'd1;
                  if (word_cnt_ff == 8'hff) begin
                     state_ff <= S_CHK;
                  end
                  if (is_read) begin
                     // one-word buffer: an unserved word is overwritten
                     dch_wdata_o <= rd_word_s;
                     dch_to_mem_o <= 1'b1;
                     dch_req_o <= 1'b1;
                     ck_ff <= {ck_ff[14:0], ck_ff[15]} ^ rd_word_s;
                     if (dch_req_o && !dch_ack_i) begin
                        late_ff <= 1'b1;
                        err_ff <= 1'b1;
                     end
                  end else begin
                     wr_word_o <= buf_ff;
                     wr_strobe_o <= 1'b1;
                     ck_ff <= {ck_ff[14:0], ck_ff[15]} ^ buf_ff;
                     if (dch_req_o && !dch_ack_i) begin
                        late_ff <= 1'b1;
                        err_ff <= 1'b1;
                     end
                     if (word_cnt_ff != 8'hff) begin
                        dch_req_o <= 1'b1;
                     end
                  end
               end
            end
            S_CHK: begin
               if (slot_p) begin
                  if (is_read) begin
                     if (rd_word_s != ck_ff) begin
                        ck_err_ff <= 1'b1;
                        err_ff <= 1'b1;
                     end
                     state_ff <= S_END;
                  end else begin
                     wr_word_o <= ck_ff;
                     wr_strobe_o <= 1'b1;
                     state_ff <= S_TAIL;
                  end
               end
            end
            S_TAIL: begin
               // write ends at the next sector mark
               if (mark_p) begin
                  wr_gate_o <= 1'b0;
                  state_ff <= S_END;
               end
            end
            S_END: begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
               end_evt_ff <= 1'b1;
               wr_gate_o <= 1'b0;
               dch_req_o <= 1'b0;
               state_ff <= S_IDLE;
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase

         // no data field, or for a preamble read no address, reached in time: preamble read or address check fails
         if (state_ff == S_MARK || state_ff == S_PRE) begin
            if (!is_fmt && nodata_cnt_ff == NODATA_CNT - 25'd1) begin
               addr_err_ff <= 1'b1;
               err_ff <= 1'b1;
               state_ff <= S_END;
            end else begin
               nodata_cnt_ff <= nodata_cnt_ff + 25'd1;
            end
         end
      end
   end
endmodule

// ---- dsk_ctrl_chk.sv ----
// Purpose: port checks for dsk_ctrl
// Assumes: bound to every dsk_ctrl instance
// Notes: one wait cycle per bus access
`timescale 1ns/100ps
module dsk_ctrl_chk (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire [2:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire dch_req_o,
   input wire dch_ack_i,
   input wire write_protect_i,
   input wire [5:0] code_jumper_i,
   input wire wr_gate_o,
   input wire wr_strobe_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // a read taken at this edge
   sequence s_rd_taken;
      avs_read_i && !avs_waitrequest_o;
   endsequence
   // a request seen first with the slave still waiting
   sequence s_req_new;
      $rose(avs_read_i | avs_write_i) && avs_waitrequest_o;
   endsequence
   a_wait_once: assert property (s_req_new |=> !avs_waitrequest_o)
      else $error("bus answer late");
   a_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_dev_code: assert property (s_rd_taken ##0 avs_address_i == 3'h5 |-> avs_readdata_o == {26'h0, code_jumper_i})
      else $error("device code wrong");
   a_unmapped_zero: assert property (s_rd_taken ##0 avs_address_i > 3'h5 |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_req_held: assert property (dch_req_o && !dch_ack_i |=> dch_req_o)
      else $error("channel request dropped");
   a_strobe_gate: assert property (wr_strobe_o |-> wr_gate_o)
      else $error("strobe outside gate");
   a_strobe_once: assert property (wr_strobe_o |=> !wr_strobe_o)
      else $error("strobe too long");
   a_protect_safe: assert property (write_protect_i && $past(write_protect_i, 4) |-> !$rose(wr_gate_o))
      else $error("protected medium written");
endmodule
bind dsk_ctrl dsk_ctrl_chk u_chk (.core_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_readdata_o, .avs_waitrequest_o, .dch_req_o, .dch_ack_i, .write_protect_i, .code_jumper_i,
   .wr_gate_o, .wr_strobe_o);

// ---- dsk_chan_model.sv ----
// Purpose: host data channel partner for dsk_ctrl
// Assumes: ack is a one-cycle pulse, read word valid with it
// Notes: delay_i sets the cycles before each ack
`timescale 1ns/100ps
module dsk_chan_model (
   input wire clk_i,
   input wire rst_n_i,
   input wire req_i,
   input wire to_mem_i,
   input wire [15:0] wdata_i,
   input wire [7:0] delay_i,
   output reg ack_o,
   output reg [15:0] rdata_o,
   output reg [15:0] last_o,
   output reg [15:0] cnt_o
);
   integer w;
   // answer each request after delay_i + 1 cycles, released word keeps moving
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!rst_n_i) begin
         w = 0;
         cnt_o <= 16'h0;
         rdata_o <= 16'h0;
      end else if (req_i && !ack_o) begin
         w = w + 1;
         if (w > delay_i) begin
            w = 0;
            ack_o <= 1'b1;
            cnt_o <= cnt_o + 16'h1;
            if (to_mem_i)
               last_o <= wdata_i;
            else
               rdata_o <= cnt_o;
         end
      end
   end
endmodule

// ---- diskette_sector_error_control_bench.sv ----
// Purpose: self-checking bench for dsk_ctrl
// Assumes: shortened deadline and no-data counts
// Notes: drive pins are stepped one word slot at a time
`timescale 1ns/100ps
module diskette_sector_error_control_bench;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg slot = 1'b0;
   reg mark = 1'b0;
   reg wp = 1'b0;
   reg [2:0] addr = 3'h0;
   reg [15:0] word = 16'h0;
   reg [7:0] dly = 8'h1;
   reg [31:0] wdat = 32'h0;
   reg [31:0] q, pre, c0;
   wire [31:0] rdat;
   wire [15:0] cwd, crd, last, cnt, wword;
   wire wreq, irq, req, tomem, ack, gate, stb;
   integer n_mismatch = 0, tests_run = 0, cyc = 0, nstr = 0, i;
   dsk_ctrl #(.LATE_CYCLES(40), .NODATA_CYCLES(3000)) u_dsk_ctrl (.core_clk_i(clk), .reset_n_i(rst_n),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .irq_o(irq), .dch_req_o(req), .dch_to_mem_o(tomem), .dch_wdata_o(cwd),
      .dch_ack_i(ack), .dch_rdata_i(crd), .word_slot_i(slot), .sector_mark_i(mark), .index_mark_i(1'b0),
      .rd_word_i(word), .write_protect_i(wp), .not_ready_i(1'b0), .code_jumper_i(6'h2d),
      .wr_gate_o(gate), .wr_strobe_o(stb), .wr_word_o(wword));
   dsk_chan_model u_dsk_chan_model (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .to_mem_i(tomem),
      .wdata_i(cwd), .delay_i(dly), .ack_o(ack), .rdata_o(crd), .last_o(last), .cnt_o(cnt));
   always #5 clk = ~clk;
   // cycle ceiling and strobe count
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (stb === 1'b1) nstr = nstr + 1;
      if (cyc == 60000) begin
         n_mismatch = n_mismatch + 1;
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////
   task test_done;
      begin
         $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
         if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   // one Avalon access, held until waitrequest is sampled low
   task bus(input w, input [2:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdat <= d;
         rd <= !w;
         wr <= w;
         do @(posedge clk); while (wreq !== 1'b0);
         q = rdat;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   task pulse_pin(input m, input [15:0] w);
      begin
         @(posedge clk);
         word <= w;
         if (m) mark <= 1'b1; else slot <= 1'b1;
         repeat (4) @(posedge clk);
         mark <= 1'b0;
         slot <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   // one sector: mark, preamble, nd data words, checkword xor ckx when nd > 0, closing mark
   task sector(input [15:0] aw, input integer nd, input [15:0] ckx);
      reg [15:0] ck;
      begin
         ck = 16'hffff;
         pulse_pin(1, 0);
         for (i = 0; i < 22; i++) pulse_pin(0, 16'h0);
         pulse_pin(0, 16'h0001);
         pulse_pin(0, aw);
         for (i = 0; i < 12; i++) pulse_pin(0, 16'h0);
         for (i = 0; i < 220; i++) pulse_pin(0, 16'ha5a5);
         for (i = 0; i < nd; i++) begin
            pulse_pin(0, i[15:0]);
            ck = {ck[14:0], ck[15]} ^ i[15:0];
         end
         if (nd > 0) begin
            // let a slow channel answer the last data request before the checkword
            repeat (70) @(posedge clk);
            bus(0, 3'h1, 0);
            pre = q;
            pulse_pin(0, ck ^ ckx);
         end
         pulse_pin(1, 0);
      end
   endtask
   // wait for done, check status, interrupt and its clearing
   task fin(input [31:0] st);
      begin
         q = 0;
         while (q[1] !== 1'b1) bus(0, 3'h1, 0);
         chk(q, st);
         repeat (3) @(posedge clk);
         chk(irq, 1);
         bus(1, 3'h3, 3);
         repeat (2) @(posedge clk);
         chk(irq, 0);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_regs;
      begin
         bus(0, 3'h1, 0); chk(q, 0);
         bus(0, 3'h4, 0); chk(q, 0);
         bus(0, 3'h5, 0); chk(q, 32'h2d);
         bus(1, 3'h6, 32'hffff);
         bus(0, 3'h6, 0); chk(q, 0);
      end
   endtask
   task t_illegal;
      begin
         bus(1, 3'h0, 32'h5);
         repeat (10) @(posedge clk);
         chk(irq, 0);
         bus(0, 3'h3, 0); chk(q, 3);
         bus(1, 3'h4, 3);
         fin(32'h46);
         for (i = 6; i < 8; i++) begin
            bus(1, 3'h0, i);
            fin(32'h46);
         end
      end
   endtask
   task t_protect;
      begin
         wp <= 1'b1;
         repeat (5) @(posedge clk);
         bus(1, 3'h0, 32'h1532);
         fin(32'h202);
         wp <= 1'b0;
      end
   endtask
   task t_nodata;
      begin
         bus(1, 3'h0, 32'h15b0);
         fin(32'h0e);
      end
   endtask
   task t_pre_wrap;
      begin
         bus(1, 3'h0, 32'h15b0);
         sector(16'h1503, 0, 0);
         fin(32'h02);
         bus(0, 3'h2, 0); chk(q, 32'h1503);
      end
   endtask
   task t_rd_good;
      begin
         c0 = cnt;
         bus(1, 3'h0, 32'h15b1);
         sector(16'h1503, 256, 0);
         fin(32'h02);
         chk(cnt - c0, 256);
         chk(last, 255);
      end
   endtask
   task t_rd_addr;
      begin
         bus(1, 3'h0, 32'h1541);
         sector(16'h1503, 0, 0);
         fin(32'h0e);
      end
   endtask
   task t_rd_ck;
      begin
         bus(1, 3'h0, 32'h1531);
         sector(16'h1503, 256, 16'h0001);
         fin(32'h16);
      end
   endtask
   task t_wr;
      begin
         c0 = nstr;
         bus(1, 3'h0, 32'h1532);
         sector(16'h1503, 256, 0);
         fin(32'h02);
         chk(nstr - c0, 257);
      end
   endtask
   task t_rd_late;
      begin
         dly = 8'd60;
         bus(1, 3'h0, 32'h1531);
         sector(16'h1503, 256, 0);
         chk(pre & 32'h25, 32'h25);
         fin(32'h26);
         dly = 8'd1;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_illegal;
      t_protect;
      t_nodata;
      t_pre_wrap;
      t_rd_good;
      t_rd_addr;
      t_rd_ck;
      t_wr;
      t_rd_late;
      test_done;
   end
endmodule
